//--- src/cvc_config.sv
// Charger termination voltage and trickle / overcurrent configuration registers
//
// Contract
// (R1) Voltage code: 8V+20mV or 12V+30mV steps
// (R2) Code bits 5:0, spare bits 7:6
// (R3) Thermal off: readback shows applied code
// (R4) Thermal on: voltage from cool/warm settings
// (R5) Trickle code bits 5:4: 100-400 mA
// (R6) Overcurrent bits 3:0: off, 3-10 A
// (R7) Thermal enable gates temperature adjustments
// (R8) Cool range lowers 180 mV per cell
// (R9) Held overcurrent 6/100 ms disables switching
// (R10) External cell count selects voltage decode
`timescale 1ns/1ps
`default_nettype none

module cvc_config #(
   parameter int          DEB_SHORT_CYC     = cvc_pkg::CVC_DEB_SHORT_CYC,  // 6 ms
   parameter int          DEB_LONG_CYC      = cvc_pkg::CVC_DEB_LONG_CYC,   // 100 ms
   parameter logic [15:0] WARM_DROP_MV_CELL = cvc_pkg::CVC_COOL_DROP_MV_CELL // Warm drop
) (
   input  wire logic        core_clk_i,                  // Core clock
   input  wire logic        reset_n_i,                   // Synchronous reset, active low
   input  wire logic        reg_wr_i,                    // Register write strobe
   input  wire logic        reg_rd_i,                    // Register read strobe
   input  wire logic [7:0]  reg_addr_i,                  // Register address
   input  wire logic [7:0]  reg_wdata_i,                 // Write data
   output logic      [7:0]  reg_rdata_o,                 // Read data, one cycle after read
   input  wire logic        thermal_profile_enable_i,    // Thermal profile on
   input  wire logic        three_cell_i,                // High for three-cell pack
   input  wire logic        cool_range_voltage_reduce_i, // Cool-range drop enabled
   input  wire logic        warm_range_voltage_adjust_i, // Warm-range drop enabled
   input  wire logic        overcurrent_debounce_select_i, // High picks long debounce
   input  wire logic        cool_zone_i,                 // Thermistor cold..cool, pin
   input  wire logic        warm_zone_i,                 // Thermistor warm..hot, pin
   input  wire logic        overcurrent_i,               // Batt-to-sys comparator, pin
   output logic      [15:0] term_voltage_mv_o,           // Applied termination voltage
   output logic      [15:0] trickle_current_ma_o,        // Trickle current setpoint
   output logic      [15:0] overcurrent_ma_o,            // Overcurrent threshold
   output logic             overcurrent_enable_o,        // Protection active
   output logic             thermal_adjusting_o,         // Temperature adjusting setpoints
   output logic             switch_disable_o             // Switching stopped by fault
);
   import cvc_pkg::*;

   // ****************************************************************
   // Decode helper
   // ****************************************************************
   // Millivolt value of a termination code for the selected cell count
   function automatic logic [15:0] volt_decode(input logic [5:0] code, input logic three);
      logic [15:0] wide;
      wide = 16'(code);
      volt_decode = three ? CVC_THREE_CELL_BASE_MV + 16'(wide * CVC_THREE_CELL_STEP_MV)
                          : CVC_TWO_CELL_BASE_MV + 16'(wide * CVC_TWO_CELL_STEP_MV); // R1 R10
   endfunction : volt_decode

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [2:0] pin_s1_reg;      // First stage, read only by the second
   logic [2:0] pin_s2_reg;      // Second stage
   logic [2:0] pin_s3_reg;      // Third stage
   logic [2:0] pin_reg;         // Accepted level
   logic [2:0] pin_next;
   wire  [2:0] pin_raw = {overcurrent_i, warm_zone_i, cool_zone_i};

   // A bit changes only once stages two and three agree
   assign pin_next = (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg ^ pin_s3_reg));

   // Shift chain
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         pin_s1_reg <= 3'h0;
         pin_s2_reg <= 3'h0;
         pin_s3_reg <= 3'h0;
         pin_reg    <= 3'h0;
      end else begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_reg    <= pin_next;
      end
   end

   wire cool_zone = pin_reg[0];     // Clean cool-zone level
   wire warm_zone = pin_reg[1];     // Clean warm-zone level
   wire oc_seen   = pin_reg[2];     // Clean overcurrent level

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [7:0] volt_cfg_reg;        // Spare bits and termination code
   logic [7:0] trkl_cfg_reg;        // Upper bits, trickle and overcurrent codes
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   wire hit_volt = (reg_addr_i == CVC_VOLT_CFG_OFFSET);
   wire hit_trkl = (reg_addr_i == CVC_TRKL_CFG_OFFSET);

   wire [5:0] term_code = volt_cfg_reg[CVC_TERM_MSB:CVC_TERM_LSB];          // R2
   wire [1:0] spare     = volt_cfg_reg[CVC_SPARE_MSB:CVC_SPARE_LSB];        // R2
   wire [1:0] trkl_code = trkl_cfg_reg[CVC_TRKL_MSB:CVC_TRKL_LSB];
   wire [3:0] oc_code   = trkl_cfg_reg[CVC_OC_MSB:CVC_OC_LSB];

   // Readback: stored code is the one applied when thermal profile is off
   assign rdata_next = !reg_rd_i ? rdata_reg :
                       hit_volt  ? {spare, term_code} :                      // R3
                       hit_trkl  ? trkl_cfg_reg : CVC_UNMAPPED_DATA;

   // Register writes; spare bits are plain storage with no charger effect
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         volt_cfg_reg <= CVC_VOLT_CFG_RESET;
         trkl_cfg_reg <= CVC_TRKL_CFG_RESET;
         rdata_reg    <= CVC_UNMAPPED_DATA;
      end else begin
         if (reg_wr_i && hit_volt) begin
            volt_cfg_reg <= reg_wdata_i;                                     // R2
         end
         if (reg_wr_i && hit_trkl) begin
            trkl_cfg_reg <= reg_wdata_i;
         end
         rdata_reg <= rdata_next;
      end
   end

   // ****************************************************************
   // Setpoint decode
   // ****************************************************************
   wire [15:0] prog_mv   = volt_decode(term_code, three_cell_i);           // R1 R10
   wire [15:0] cells     = three_cell_i ? CVC_THREE_CELLS : CVC_TWO_CELLS;
   wire        cool_drop = thermal_profile_enable_i && cool_zone
                           && cool_range_voltage_reduce_i;                   // R4 R8
   wire        warm_drop = thermal_profile_enable_i && warm_zone
                           && warm_range_voltage_adjust_i;                   // R4
   wire [15:0] cool_mv   = 16'(CVC_COOL_DROP_MV_CELL * cells);              // R8
   wire [15:0] warm_mv   = 16'(WARM_DROP_MV_CELL * cells);
   // Without the profile neither drop applies, so temperature has no effect
   wire [15:0] applied_mv = cool_drop ? prog_mv - cool_mv :
                            warm_drop ? prog_mv - warm_mv : prog_mv;          // R7
   wire [15:0] trkl_ma   = 16'(16'(trkl_code) * CVC_TRKL_STEP_MA) + CVC_TRKL_STEP_MA; // R5
   wire        oc_on     = (oc_code != CVC_OC_DISABLED);                     // R6
   wire [15:0] oc_ma     = oc_on ? CVC_OC_BASE_MA
                           + 16'(16'(oc_code - CVC_OC_FIRST) * CVC_OC_STEP_MA) : 16'h0000; // R6
   wire        adjusting = thermal_profile_enable_i && (cool_zone || warm_zone); // R7

   // Output flops
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         term_voltage_mv_o    <= CVC_TWO_CELL_BASE_MV;
         trickle_current_ma_o <= CVC_TRKL_STEP_MA;
         overcurrent_ma_o     <= 16'h0000;
         overcurrent_enable_o <= 1'b0;
         thermal_adjusting_o  <= 1'b0;
      end else begin
         term_voltage_mv_o    <= applied_mv;
         trickle_current_ma_o <= trkl_ma;
         overcurrent_ma_o     <= oc_ma;
         overcurrent_enable_o <= oc_on;
         thermal_adjusting_o  <= adjusting;
      end
   end

   assign reg_rdata_o = rdata_reg;

   // ****************************************************************
   // Overcurrent debounce
   // ****************************************************************
   // A disabled threshold never trips, even if the comparator fires
   cvc_oc_debounce #(
      .SHORT_CYC     (DEB_SHORT_CYC),
      .LONG_CYC      (DEB_LONG_CYC)
   ) u_oc_debounce (
      .core_clk_i    (core_clk_i),
      .reset_n_i     (reset_n_i),
      .fault_i       (oc_seen && oc_on),                                     // R9
      .long_select_i (overcurrent_debounce_select_i),
      .trip_o        (switch_disable_o)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence volt_write_s;
      reg_wr_i && hit_volt;
   endsequence

   volt_write_store_a: assert property (volt_write_s |=> volt_cfg_reg == $past(reg_wdata_i)) // R2
      else $error("voltage register write not stored");
   volt_read_back_a: assert property (reg_rd_i && hit_volt && !reg_wr_i ##1 1'b1 // R3
      |-> reg_rdata_o == $past(volt_cfg_reg))
      else $error("voltage readback wrong");
   two_cell_decode_a: assert property (!three_cell_i && !cool_drop && !warm_drop // R1
      |=> term_voltage_mv_o == CVC_TWO_CELL_BASE_MV + 16'(16'($past(term_code)) * 16'h0014))
      else $error("two-cell decode wrong");
   three_cell_decode_a: assert property (three_cell_i && !cool_drop && !warm_drop // R10
      |=> term_voltage_mv_o == CVC_THREE_CELL_BASE_MV + 16'(16'($past(term_code)) * 16'h001E))
      else $error("three-cell decode wrong");
   cool_range_drop_a: assert property (cool_drop // R8
      |=> term_voltage_mv_o == $past(prog_mv) - 16'(16'h00B4 * $past(cells)))
      else $error("cool-range drop wrong");
   profile_off_fixed_a: assert property (!thermal_profile_enable_i // R7
      |=> term_voltage_mv_o == $past(prog_mv) && !thermal_adjusting_o)
      else $error("setpoint moved with profile off");
   trickle_decode_a: assert property (1'b1 // R5
      |=> trickle_current_ma_o == 16'(16'($past(trkl_code)) * 16'h0064) + 16'h0064)
      else $error("trickle decode wrong");
   oc_disable_code_a: assert property (oc_code == CVC_OC_DISABLED // R6
      |=> !overcurrent_enable_o ##1 !switch_disable_o)
      else $error("overcurrent active while disabled");
   oc_top_code_a: assert property (oc_code == 4'hF |=> overcurrent_ma_o == 16'h2710) // R6
      else $error("top overcurrent threshold wrong");

endmodule : cvc_config

`default_nettype wire

//--- src/cvc_oc_debounce.sv
// Overcurrent debounce timer that disables switching after a held fault
`timescale 1ns/1ps
`default_nettype none

module cvc_oc_debounce #(
   parameter int SHORT_CYC = cvc_pkg::CVC_DEB_SHORT_CYC,   // Short debounce length
   parameter int LONG_CYC  = cvc_pkg::CVC_DEB_LONG_CYC     // Long debounce length
) (
   input  wire logic core_clk_i,       // Core clock
   input  wire logic reset_n_i,        // Synchronous reset, active low
   input  wire logic fault_i,          // Qualified overcurrent condition
   input  wire logic long_select_i,    // High picks the long debounce
   output logic      trip_o            // Switching disabled
);
   import cvc_pkg::*;

   // ****************************************************************
   // Counter
   // ****************************************************************
   localparam int CW = $clog2(LONG_CYC + 1);           // Fits the longer length

   logic [CW-1:0] count_reg;                           // Cycles the fault has held
   logic [CW-1:0] count_next;
   logic          trip_reg;                            // Registered trip, cleared when the fault drops
   logic          trip_next;
   wire  [CW-1:0] limit = long_select_i ? CW'(LONG_CYC) : CW'(SHORT_CYC);
   wire           reached = (count_reg >= limit - CW'(1));

   // A drop of the fault restarts the wait; trip lasts while it persists
   assign count_next = !fault_i ? '0 : (reached ? count_reg : count_reg + CW'(1));  // R9
   assign trip_next  = fault_i && (trip_reg || reached);                          // R9

   // Counter and trip flops
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         count_reg <= '0;
         trip_reg  <= 1'b0;
      end else begin
         count_reg <= count_next;
         trip_reg  <= trip_next;
      end
   end

   assign trip_o = trip_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   trip_needs_fault_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i) // R9
      $rose(trip_reg) |-> $past(fault_i) && $past(count_reg) >= $past(limit) - CW'(1))
      else $error("trip rose before debounce expired");

endmodule : cvc_oc_debounce

`default_nettype wire

//--- src/cvc_pkg.sv
// Constants shared by the charger voltage and current configuration block
`default_nettype none

package cvc_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0]  CVC_VOLT_CFG_OFFSET = 8'h1A;   // Termination voltage register
   localparam logic [7:0]  CVC_TRKL_CFG_OFFSET = 8'h1B;   // Trickle / overcurrent register
   localparam logic [7:0]  CVC_VOLT_CFG_RESET  = 8'h00;   // All fields zero
   localparam logic [7:0]  CVC_TRKL_CFG_RESET  = 8'h44;   // Upper bits 0x1, overcurrent 0x4
   localparam logic [7:0]  CVC_UNMAPPED_DATA   = 8'h00;   // Read of any other address

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CVC_TERM_MSB  = 5;   // Termination voltage code
   localparam int CVC_TERM_LSB  = 0;
   localparam int CVC_SPARE_MSB = 7;   // Spare storage
   localparam int CVC_SPARE_LSB = 6;
   localparam int CVC_TRKL_MSB  = 5;   // Trickle current code
   localparam int CVC_TRKL_LSB  = 4;
   localparam int CVC_OC_MSB    = 3;   // Batt-to-sys overcurrent code
   localparam int CVC_OC_LSB    = 0;

   // ****************************************************************
   // Setpoint decode (mV and mA)
   // ****************************************************************
   localparam logic [15:0] CVC_TWO_CELL_BASE_MV   = 16'h1F40;  // 8000 mV
   localparam logic [15:0] CVC_TWO_CELL_STEP_MV   = 16'h0014;  // 20 mV
   localparam logic [15:0] CVC_THREE_CELL_BASE_MV = 16'h2EE0;  // 12000 mV
   localparam logic [15:0] CVC_THREE_CELL_STEP_MV = 16'h001E;  // 30 mV
   localparam logic [15:0] CVC_COOL_DROP_MV_CELL  = 16'h00B4;  // 180 mV per cell
   localparam logic [15:0] CVC_TWO_CELLS          = 16'h0002;
   localparam logic [15:0] CVC_THREE_CELLS        = 16'h0003;
   localparam logic [15:0] CVC_TRKL_STEP_MA       = 16'h0064;  // 100 mA per code
   localparam logic [15:0] CVC_OC_BASE_MA         = 16'h0BB8;  // 3000 mA at code 1
   localparam logic [15:0] CVC_OC_STEP_MA         = 16'h01F4;  // 500 mA per code
   localparam logic [3:0]  CVC_OC_DISABLED        = 4'h0;      // Protection off
   localparam logic [3:0]  CVC_OC_FIRST           = 4'h1;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CVC_CLK_PERIOD_NS = 10;        // 100 MHz core clock
   localparam int CVC_NS_PER_MS     = 1000000;
   localparam int CVC_DEB_SHORT_MS  = 6;         // Short overcurrent debounce
   localparam int CVC_DEB_LONG_MS   = 100;       // Long overcurrent debounce
   localparam int CVC_DEB_SHORT_CYC =
      (CVC_DEB_SHORT_MS * CVC_NS_PER_MS + CVC_CLK_PERIOD_NS - 1) / CVC_CLK_PERIOD_NS;
   localparam int CVC_DEB_LONG_CYC  =
      (CVC_DEB_LONG_MS * CVC_NS_PER_MS + CVC_CLK_PERIOD_NS - 1) / CVC_CLK_PERIOD_NS;

endpackage : cvc_pkg

`default_nettype wire

//--- testbench/cvc_config_tb_top.sv
// Self-checking bench for the charger voltage and current configuration block
`timescale 1ns/1ps
`default_nettype none

module cvc_config_tb_top;
   import cvc_pkg::*;

   // ****************************************************************
   // Stimulus and observed signals
   // ****************************************************************
   logic        clk = 1'b0;        // 100 MHz core clock
   logic        rst_n = 1'b0;      // Synchronous reset, active low
   logic        wr = 1'b0;         // Write strobe
   logic        rd = 1'b0;         // Read strobe
   logic [7:0]  addr = 8'h00;      // Register address
   logic [7:0]  wdata = 8'h00;     // Write data
   logic        prof = 1'b0;       // Thermal profile enable
   logic        three = 1'b0;      // Cell count select
   logic        cool_en = 1'b0;    // Cool-range drop enable
   logic        warm_en = 1'b0;    // Warm-range drop enable
   logic        deb_long = 1'b0;   // Long debounce select
   logic        cool_z = 1'b0;     // Cool zone pin
   logic        warm_z = 1'b0;     // Warm zone pin
   logic        oc_pin = 1'b0;     // Overcurrent comparator pin
   logic [7:0]  rdata;             // Read data
   logic [15:0] volt_mv;           // Applied termination voltage
   logic [15:0] trkl_ma;           // Trickle current
   logic [15:0] oc_ma;             // Overcurrent threshold
   logic        oc_en;             // Protection active
   logic        adj;               // Thermal adjusting
   logic        sw_dis;            // Switching stopped
   int          num_errors = 0;    // Mismatch count
   int          samples_checked = 0; // Comparison count
   int          cyc = 0;           // Timeout counter

   // Short debounce lengths keep the run brief; expectations follow them
   localparam int SHORT_C = 8;
   localparam int LONG_C  = 20;

   cvc_config #(.DEB_SHORT_CYC(SHORT_C), .DEB_LONG_CYC(LONG_C)) i_dut (
      .core_clk_i(clk), .reset_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .thermal_profile_enable_i(prof), .three_cell_i(three),
      .cool_range_voltage_reduce_i(cool_en), .warm_range_voltage_adjust_i(warm_en),
      .overcurrent_debounce_select_i(deb_long), .cool_zone_i(cool_z),
      .warm_zone_i(warm_z), .overcurrent_i(oc_pin), .term_voltage_mv_o(volt_mv),
      .trickle_current_ma_o(trkl_ma), .overcurrent_ma_o(oc_ma),
      .overcurrent_enable_o(oc_en), .thermal_adjusting_o(adj),
      .switch_disable_o(sw_dis));

   // ****************************************************************
   // Clock and timeout
   // ****************************************************************
   initial begin
      forever #5 clk = ~clk;
   end

   // Ceiling well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         give_verdict();
      end
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Strobe held one full cycle, outputs settled two edges later
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      addr = a; wdata = d; wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(2);
   endtask : reg_write

   // Data lands on the edge after the strobe and stands afterwards
   task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
      addr = a; rd = 1'b1;
      tick(1);
      rd = 1'b0;
      tick(1);
      chk("read data", {8'h00, exp}, {8'h00, rdata});
   endtask : reg_read

   task automatic give_verdict();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      reg_read(CVC_VOLT_CFG_OFFSET, 8'h00);
      reg_read(CVC_TRKL_CFG_OFFSET, 8'h44);
      chk("volt", 16'h1F40, volt_mv);
      chk("trickle", 16'h0064, trkl_ma);
      chk("oc thr", 16'h1194, oc_ma);
      chk("oc en", 16'h0001, {15'h0, oc_en});
   endtask : t_reset

   // Code extremes in both cell counts, spare bits kept and inert
   task automatic t_volt();
      logic [5:0]  codes [3] = '{6'h00, 6'h01, 6'h3F};
      logic [15:0] exp_mv;                        // Expected setpoint
      for (int c = 0; c < 2; c++) begin
         three = c[0];
         foreach (codes[i]) begin
            reg_write(CVC_VOLT_CFG_OFFSET, {2'b11, codes[i]});
            exp_mv = c ? 16'h2EE0 + 16'h001E * codes[i] : 16'h1F40 + 16'h0014 * codes[i];
            chk("volt", exp_mv, volt_mv);
            reg_read(CVC_VOLT_CFG_OFFSET, {2'b11, codes[i]});
         end
      end
      three = 1'b0;
      reg_write(8'h1C, 8'h3F);
      reg_read(8'h1C, CVC_UNMAPPED_DATA);
      chk("volt", 16'h242C, volt_mv);
   endtask : t_volt

   // Every trickle code, overcurrent off, first and last code
   task automatic t_trkl();
      logic [3:0]  ocs [4] = '{4'h0, 4'h1, 4'h4, 4'hF};
      logic [15:0] exp_ma;                        // Expected threshold
      for (int t = 0; t < 4; t++) begin
         reg_write(CVC_TRKL_CFG_OFFSET, {2'b10, t[1:0], ocs[t]});
         chk("trickle", 16'h0064 * 16'(t + 1), trkl_ma);
         exp_ma = (ocs[t] == 4'h0) ? 16'h0000 : 16'h0BB8 + 16'h01F4 * 16'(ocs[t] - 4'h1);
         chk("oc thr", exp_ma, oc_ma);
         chk("oc en", {15'h0, ocs[t] != 4'h0}, {15'h0, oc_en});
         reg_read(CVC_TRKL_CFG_OFFSET, {2'b10, t[1:0], ocs[t]});
      end
   endtask : t_trkl

   // Zone drops only with the profile on; cool zone, then warm zone alone
   task automatic t_therm();
      reg_write(CVC_VOLT_CFG_OFFSET, 8'h14);
      cool_en = 1'b1; warm_en = 1'b1; cool_z = 1'b1;
      tick(8);
      chk("volt off", 16'h20D0, volt_mv);
      chk("adj off", 16'h0000, {15'h0, adj});
      prof = 1'b1;
      tick(3);
      chk("volt cool", 16'h1F68, volt_mv);
      chk("adj on", 16'h0001, {15'h0, adj});
      three = 1'b1;
      tick(3);
      chk("volt cool 3s", 16'h3138 - 16'h021C, volt_mv);
      cool_z = 1'b0; warm_z = 1'b1;
      tick(8);
      chk("volt warm", 16'h3138 - 16'h0003 * CVC_COOL_DROP_MV_CELL, volt_mv);
      cool_en = 1'b0; warm_en = 1'b0;
      tick(3);
      chk("volt none", 16'h3138, volt_mv);
      reg_read(CVC_VOLT_CFG_OFFSET, 8'h14);
      prof = 1'b0; warm_z = 1'b0; three = 1'b0;
      tick(8);
   endtask : t_therm

   // Held fault trips after its debounce; short fault does not
   task automatic t_oc(input logic sel, input int lim);
      int n;
      deb_long = sel;
      reg_write(CVC_TRKL_CFG_OFFSET, 8'h41);
      oc_pin = 1'b1;
      tick(lim - 2);
      oc_pin = 1'b0;
      tick(lim + 10);
      chk("no trip short", 16'h0000, {15'h0, sw_dis});
      oc_pin = 1'b1;
      tick(lim + 2);
      chk("no trip early", 16'h0000, {15'h0, sw_dis});
      n = 0;
      while (sw_dis !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      chk("trip", 16'h0001, {15'h0, sw_dis});
      // Four edges of pin filtering, then the full debounce length
      chk("trip delay", 16'h0002, 16'(n));
      reg_write(CVC_TRKL_CFG_OFFSET, 8'h40);
      tick(2);
      chk("code off", 16'h0000, {15'h0, sw_dis});
      oc_pin = 1'b0;
      tick(8);
   endtask : t_oc

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      tick(10);
      rst_n = 1'b1;
      tick(2);
      t_reset();
      t_volt();
      t_trkl();
      t_therm();
      t_oc(1'b0, SHORT_C);
      t_oc(1'b1, LONG_C);
      give_verdict();
   end

endmodule : cvc_config_tb_top

`default_nettype wire
